// ==== rtl/pac_pkg.sv ====
// Package: constants for the PA control sequencer
package pac_pkg;

   // ==========================================================
   // Clock and timing
   // ==========================================================
   localparam int unsigned CLK_PERIOD_PS     = 4000;
   localparam int unsigned PA_ON_DELAY_NS    = 62500;
   localparam int unsigned PLL_SHIFT_DELAY_NS = 6500;
   localparam int unsigned RX_MODE_DELAY_NS  = 70000;
   localparam int unsigned PA_OFF_DELAY_NS   = 100;
   // Least times round up, longest times round down
   localparam int unsigned PA_ON_CYCLES =
      (PA_ON_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned PLL_SHIFT_CYCLES =
      (PLL_SHIFT_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned RX_MODE_CYCLES =
      (RX_MODE_DELAY_NS * 1000) / CLK_PERIOD_PS;
   localparam int unsigned PA_OFF_CYCLES =
      ((PA_OFF_DELAY_NS * 1000) / CLK_PERIOD_PS) > 0 ?
      ((PA_OFF_DELAY_NS * 1000) / CLK_PERIOD_PS) : 1;
   localparam int unsigned CNT_W = 16;

   // ==========================================================
   // Field widths and reset values
   // ==========================================================
   localparam int unsigned TEST_SEL_W       = 3;
   localparam logic [2:0]  TEST_SEL_NORMAL  = 3'h0;
   localparam logic        TPC_RST          = 1'b0;
   localparam logic        SLOT_RST         = 1'b1;

   // ==========================================================
   // Sequencer states
   // ==========================================================
   typedef enum logic [3:0] {
      PAC_RX      = 4'h1,
      PAC_TX_WAIT = 4'h2,
      PAC_TX_ON   = 4'h4,
      PAC_RX_WAIT = 4'h8
   } pac_state_t;

endpackage

// ==== rtl/pac_tick_if.sv ====
// Interface: timer start, load limit, count and busy between sequencer and delay timer
`timescale 1ns/1ns
interface pac_tick_if;
   import pac_pkg::*;
   logic             start;
   logic [CNT_W-1:0] load;
   logic [CNT_W-1:0] count;
   logic             busy;
   modport timer (input start, input load, output count, output busy);
   modport user  (output start, output load, input count, input busy);
endinterface

// ==== rtl/pac_delay_timer.sv ====
// Module: elapsed-cycle counter for sequencing delays
`timescale 1ns/1ns
module pac_delay_timer
   import pac_pkg::*;
(
   // Clock and reset
   input  wire logic  mclk_in,
   input  wire logic  sys_rst_in,
   // Control
   pac_tick_if.timer  tick
);
   logic [CNT_W-1:0] count_q;
   logic             busy_q;

   // ==========================================================
   // Counter
   // ==========================================================
   // Counts up from start until it reaches the load limit
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         count_q <= '0;
         busy_q  <= 1'b0;
      end else if (tick.start) begin
         count_q <= '0;
         busy_q  <= 1'b1;
      end else if (busy_q) begin
         count_q <= count_q + 16'h0001;
         if (count_q == tick.load) begin
            busy_q <= 1'b0;
         end
      end
   end

   assign tick.count = count_q;
   assign tick.busy  = busy_q;
endmodule

// ==== rtl/pac_sequencer.sv ====
// Module: PA enable and auxiliary pin sequencer for the radio
//
// Function
// - PA enable high only while PA active
// - PLL unlock forces PA enable low
// - Power control bit governs aux pin drain
// - Aux pin adopts bit at transmit start
// - PA enable rises 62.5 us after fall
// - PLL shift 6.5 us after rise
// - Receive mode within 70 us after rise
// - PA enable drops under 0.1 us
// - Analog test repurposes strength and aux pins
// - Aux drain floats at 0, grounds at 1
// - Digital test repurposes data and PA pins
`timescale 1ns/1ns
module pac_sequencer
   import pac_pkg::*;
(
   // Clock and reset
   input  wire logic                  mclk_in,
   input  wire logic                  sys_rst_in,
   // Baseband slot control and configuration
   input  wire logic                  rx_slot_ctrl_in,
   input  wire logic                  tx_power_ctrl_bit_in,
   input  wire logic                  aux_data_mode_in,
   input  wire logic [TEST_SEL_W-1:0] analog_test_sel_in,
   input  wire logic [TEST_SEL_W-1:0] digital_test_sel_in,
   // Synthesizer and receive chain
   input  wire logic                  pll_locked_in,
   input  wire logic                  rx_data_in,
   input  wire logic                  dig_test_pa_in,
   input  wire logic                  dig_test_data_in,
   // Outputs
   output logic                       pa_enable_out,
   output logic                       rx_data_out,
   output logic                       pll_shift_out,
   output logic                       rx_mode_out,
   output logic                       aux_drain_oe_out,
   output logic                       aux_drain_o_out,
   output logic                       aux_data_sel_out,
   output logic                       analog_test_active_out
);
   pac_tick_if tick ();

   pac_state_t state_q;
   pac_state_t state_d;
   logic       slot_q;
   logic       slot_prev_q;
   logic       tpc_latched_q;
   logic       pa_q;
   logic       pll_shift_q;
   logic       rx_mode_q;
   logic       rx_data_q;
   logic       fall_ev;
   logic       rise_ev;
   logic       done_ev;
   logic       dig_test_on;

   pac_delay_timer u_timer (
      .mclk_in    (mclk_in),
      .sys_rst_in (sys_rst_in),
      .tick       (tick)
   );

   // ==========================================================
   // Helpers
   // ==========================================================
   // Any nonzero select takes the pins away from normal use
   function automatic logic test_on(input logic [TEST_SEL_W-1:0] sel);
      return sel != TEST_SEL_NORMAL;
   endfunction

   // Transmit phase waits for PA turn-on, receive phase for rx mode
   function automatic logic [CNT_W-1:0] phase_limit(input logic tx);
      if (tx) begin
         return CNT_W'(PA_ON_CYCLES - 3);
      end else begin
         return CNT_W'(RX_MODE_CYCLES - 3);
      end
   endfunction

   assign dig_test_on = test_on(digital_test_sel_in);

   // ==========================================================
   // Slot edge detection
   // ==========================================================
   // Input is registered twice; edges compare the two register stages
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         slot_q      <= SLOT_RST;
         slot_prev_q <= SLOT_RST;
      end else begin
         slot_q      <= rx_slot_ctrl_in;
         slot_prev_q <= slot_q;
      end
   end

   assign fall_ev = slot_prev_q & ~slot_q;
   assign rise_ev = ~slot_prev_q & slot_q;
   assign done_ev = tick.busy && (tick.count == tick.load);

   // ==========================================================
   // Timer control
   // ==========================================================
   always_comb begin
      tick.start = fall_ev | rise_ev;
      // Limit must stand for the whole delay, not just the start cycle
      if (fall_ev) begin
         tick.load = phase_limit(1'b1);
      end else if (rise_ev) begin
         tick.load = phase_limit(1'b0);
      end else begin
         tick.load = phase_limit(state_q == PAC_TX_WAIT);
      end
   end

   // ==========================================================
   // Sequencer state machine
   // ==========================================================
   always_comb begin
      state_d = state_q;
      case (state_q)
         PAC_RX: begin
            if (fall_ev) state_d = PAC_TX_WAIT;
         end
         PAC_TX_WAIT: begin
            if (rise_ev) state_d = PAC_RX_WAIT;
            else if (done_ev) state_d = PAC_TX_ON;
         end
         PAC_TX_ON: begin
            if (rise_ev) state_d = PAC_RX_WAIT;
         end
         PAC_RX_WAIT: begin
            if (fall_ev) state_d = PAC_TX_WAIT;
            else if (done_ev) state_d = PAC_RX;
         end
         default: state_d = PAC_RX;
      endcase
   end

   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) state_q <= PAC_RX;
      else state_q <= state_d;
   end

   // ==========================================================
   // PA enable
   // ==========================================================
   // Drops on the rise edge combinationally below, far under 0.1 us
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         pa_q <= 1'b0;
      end else begin
         pa_q <= (state_d == PAC_TX_ON) && !rise_ev;
      end
   end

   always_comb begin
      if (dig_test_on) begin
         pa_enable_out = dig_test_pa_in;
      end else begin
         // Gated live so an unlock or slot rise cuts it at once
         pa_enable_out = pa_q && pll_locked_in && !rise_ev;
      end
   end

   // ==========================================================
   // PLL shift and receive mode
   // ==========================================================
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         pll_shift_q <= 1'b0;
      end else if (fall_ev) begin
         pll_shift_q <= 1'b0;
      end else if ((state_q == PAC_RX_WAIT)
                   && (tick.count == CNT_W'(PLL_SHIFT_CYCLES - 3))) begin
         pll_shift_q <= 1'b1;
      end
   end

   // Receive mode waits out the full settling delay
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         rx_mode_q <= 1'b1;
      end else if (fall_ev) begin
         rx_mode_q <= 1'b0;
      end else if ((state_q == PAC_RX_WAIT) && done_ev) begin
         rx_mode_q <= 1'b1;
      end
   end

   assign pll_shift_out = pll_shift_q;
   assign rx_mode_out   = rx_mode_q;

   // ==========================================================
   // Auxiliary pin
   // ==========================================================
   // Bit may change any time; only the transmit-slot start samples it
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) tpc_latched_q <= TPC_RST;
      else if (fall_ev) tpc_latched_q <= tx_power_ctrl_bit_in;
   end

   always_comb begin
      analog_test_active_out = test_on(analog_test_sel_in);
      aux_data_sel_out = aux_data_mode_in && !analog_test_active_out;
      aux_drain_o_out  = 1'b0;
      // Drive low only for a latched 1, else float
      aux_drain_oe_out = !aux_data_mode_in && !analog_test_active_out
                         && tpc_latched_q;
   end

   // ==========================================================
   // Receive data output
   // ==========================================================
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         rx_data_q <= 1'b0;
      end else if (dig_test_on) begin
         rx_data_q <= dig_test_data_in;
      end else begin
         rx_data_q <= rx_data_in;
      end
   end

   assign rx_data_out = rx_data_q;
endmodule

// ==== verif/pac_sequencer_asserts.sv ====
// Checker: timing and gating properties of the PA sequencer
`timescale 1ns/1ns
module pac_sequencer_asserts
   import pac_pkg::*;
(
   // Clock and reset
   input  wire logic                  mclk_in,
   input  wire logic                  sys_rst_in,
   // Watched inputs
   input  wire logic                  rx_slot_ctrl_in,
   input  wire logic                  aux_data_mode_in,
   input  wire logic [TEST_SEL_W-1:0] analog_test_sel_in,
   input  wire logic [TEST_SEL_W-1:0] digital_test_sel_in,
   input  wire logic                  pll_locked_in,
   // Watched outputs
   input  wire logic                  pa_enable_out,
   input  wire logic                  pll_shift_out,
   input  wire logic                  rx_mode_out,
   input  wire logic                  aux_drain_oe_out,
   input  wire logic                  analog_test_active_out
);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (sys_rst_in);
   // ==========================================================
   // Saturating cycle counts since the last slot edges
   // ==========================================================
   logic [CNT_W-1:0] fall_q;
   logic [CNT_W-1:0] rise_q;
   logic             slot_q;
   logic             norm;
   assign norm = (digital_test_sel_in == TEST_SEL_NORMAL);
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         slot_q <= SLOT_RST;
         fall_q <= '1;
         rise_q <= '1;
      end else begin
         slot_q <= rx_slot_ctrl_in;
         fall_q <= (slot_q && !rx_slot_ctrl_in) ? CNT_W'(1) :
                   (&fall_q) ? fall_q : fall_q + 1'b1;
         rise_q <= (!slot_q && rx_slot_ctrl_in) ? CNT_W'(1) :
                   (&rise_q) ? rise_q : rise_q + 1'b1;
      end
   end
   // ==========================================================
   // Properties
   // ==========================================================
   property p_lock; !pll_locked_in && norm |-> !pa_enable_out; endproperty
   a_lock: assert property (p_lock) else $error("PA on unlocked");
   property p_only_tx; pa_enable_out && norm |-> !rx_mode_out; endproperty
   a_only_tx: assert property (p_only_tx) else $error("PA in rx");
   property p_off;
      $rose(rx_slot_ctrl_in) && norm |-> ##[0:3] !pa_enable_out;
   endproperty
   a_off: assert property (p_off) else $error("PA late off");
   property p_early;
      pa_enable_out && norm |-> fall_q >= PA_ON_CYCLES - 3;
   endproperty
   a_early: assert property (p_early) else $error("PA early");
   property p_late;
      fall_q == PA_ON_CYCLES + 3 && !rx_slot_ctrl_in && pll_locked_in
      && norm |-> pa_enable_out;
   endproperty
   a_late: assert property (p_late) else $error("PA late on");
   property p_shift;
      rise_q == PLL_SHIFT_CYCLES + 3 && rx_slot_ctrl_in |-> pll_shift_out;
   endproperty
   a_shift: assert property (p_shift) else $error("shift late");
   property p_rx;
      rise_q == RX_MODE_CYCLES + 3 && rx_slot_ctrl_in |-> rx_mode_out;
   endproperty
   a_rx: assert property (p_rx) else $error("rx mode late");
   // Mode changes legally move the pin, so they are excluded
   property p_hold;
      $changed(aux_drain_oe_out) && $stable(aux_data_mode_in) &&
      $stable(analog_test_sel_in) |-> fall_q <= 5;
   endproperty
   a_hold: assert property (p_hold) else $error("aux moved");
   property p_atest;
      analog_test_sel_in != 3'h0 |-> ##[0:1] analog_test_active_out;
   endproperty
   a_atest: assert property (p_atest) else $error("no test port");
endmodule

bind pac_sequencer pac_sequencer_asserts chk_u (.mclk_in(mclk_in),
   .sys_rst_in(sys_rst_in), .rx_slot_ctrl_in(rx_slot_ctrl_in),
   .aux_data_mode_in(aux_data_mode_in),
   .analog_test_sel_in(analog_test_sel_in),
   .digital_test_sel_in(digital_test_sel_in),
   .pll_locked_in(pll_locked_in), .pa_enable_out(pa_enable_out),
   .pll_shift_out(pll_shift_out), .rx_mode_out(rx_mode_out),
   .aux_drain_oe_out(aux_drain_oe_out),
   .analog_test_active_out(analog_test_active_out));

// ==== verif/pac_aux_pin_model.sv ====
// Partner: pulled-up aux pin on the board side
`timescale 1ns/1ns
module pac_aux_pin_model (
   // Drain controls from the block
   input  wire logic oe_in,
   input  wire logic o_in,
   // Resolved pin level
   output wire logic pin_out
);
   // Pull-up holds the pin while the drain floats
   assign pin_out = oe_in ? o_in : 1'b1;
endmodule

// ==== verif/pac_sequencer_tb_top.sv ====
// Testbench: top level for the PA control sequencer
`timescale 1ns/1ns
module pac_sequencer_tb_top;
   import pac_pkg::*;
   logic       mclk_in, sys_rst_in, slot, tx_power_ctrl_bit, amode, lock, rxd, dpa, ddat;
   logic [2:0] asel, dsel;
   logic       pa, rxo, shift, rxm, oe, o, dsel_o, aact, pin;
   int         error_cnt, n_checks;

   always #2 mclk_in = ~mclk_in;

   pac_sequencer dut_u (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
      .rx_slot_ctrl_in(slot), .tx_power_ctrl_bit_in(tx_power_ctrl_bit),
      .aux_data_mode_in(amode), .analog_test_sel_in(asel),
      .digital_test_sel_in(dsel), .pll_locked_in(lock), .rx_data_in(rxd),
      .dig_test_pa_in(dpa), .dig_test_data_in(ddat), .pa_enable_out(pa),
      .rx_data_out(rxo), .pll_shift_out(shift), .rx_mode_out(rxm),
      .aux_drain_oe_out(oe), .aux_drain_o_out(o), .aux_data_sel_out(dsel_o),
      .analog_test_active_out(aact));
   pac_aux_pin_model pin_u (.oe_in(oe), .o_in(o), .pin_out(pin));

   task automatic chk(input logic got, input logic exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t level %b", $time, got);
      end
   endtask
   task automatic chk_n(input int got, input int lo, input int hi);
      n_checks++;
      if (got < lo || got > hi) begin
         error_cnt++;
         $display("[FAIL] %0t count %0d", $time, got);
      end
   endtask
   // Bounded wait, so a stuck output ends as a bad count
   task automatic wait_hi(input int sel, output int n);
      logic v;
      n = 0;
      v = 1'b0;
      while (v !== 1'b1 && n < 20000) begin
         @(negedge mclk_in);
         n++;
         v = (sel == 0) ? pa : (sel == 1) ? shift : rxm;
      end
   endtask
   task automatic t_modes();
      {dsel, dpa, ddat} = 5'h13;
      repeat (2) @(negedge mclk_in);
      chk(pa, 1'b1);
      chk(rxo, 1'b1);
      {dsel, dpa, ddat, rxd, asel, amode} = 10'h005;
      repeat (2) @(negedge mclk_in);
      chk(pa, 1'b0);
      chk(rxo, 1'b0);
      chk(aact, 1'b1);
      asel = 3'h0;
      rxd = 1'b1;
      repeat (2) @(negedge mclk_in);
      chk(rxo, 1'b1);
      chk(dsel_o, 1'b1);
      chk(pin, 1'b1);
      amode = 1'b0;
   endtask
   task automatic t_slot(input logic bit_v, input logic drop);
      int n1;
      int n2;
      tx_power_ctrl_bit = bit_v;
      @(negedge mclk_in);
      slot = 1'b0;
      wait_hi(0, n1);
      chk_n(n1, PA_ON_CYCLES - 3, PA_ON_CYCLES + 3);
      chk(pin, ~bit_v);
      chk(rxm, 1'b0);
      tx_power_ctrl_bit = ~bit_v;
      repeat (4) @(negedge mclk_in);
      chk(pin, ~bit_v);
      asel = 3'h1;
      @(negedge mclk_in);
      chk(pin, 1'b1);
      asel = 3'h0;
      if (drop) begin
         lock = 1'b0;
         @(negedge mclk_in);
         chk(pa, 1'b0);
         lock = 1'b1;
      end
      slot = 1'b1;
      @(negedge mclk_in);
      chk(pa, 1'b0);
      wait_hi(1, n1);
      chk_n(n1 + 1, PLL_SHIFT_CYCLES - 3, PLL_SHIFT_CYCLES + 3);
      wait_hi(2, n2);
      chk_n(n1 + n2 + 1, 1, RX_MODE_CYCLES + 3);
   endtask
   task automatic final_report();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial begin
      {mclk_in, sys_rst_in, slot, lock} = 4'h7;
      {tx_power_ctrl_bit, amode, rxd, dpa, ddat, asel, dsel} = 11'h000;
      error_cnt = 0;
      n_checks = 0;
      repeat (12) @(negedge mclk_in);
      sys_rst_in = 1'b0;
      @(negedge mclk_in);
      t_modes();
      t_slot(1'b1, 1'b0);
      t_slot(1'b0, 1'b1);
      final_report();
   end
   // Two slots need about 66300 cycles
   initial begin
      repeat (90000) @(posedge mclk_in);
      error_cnt++;
      final_report();
   end
endmodule
